/* pcs_pkg.sv */
// Purpose: Shared constants and types for the packet control symbol codec
// Assumes: 32-bit aligned symbol, second half the complement of the first
// Notes: Field positions inside the first half are parameters of this package
package pcs_pkg;
    // Symbol type value for packet control symbols
    localparam logic [2:0] PCS_STYPE_PKT = 3'h4;
    // Field positions in the first 16-bit half
    localparam int PCS_STYPE_LSB = 13;
    localparam int PCS_SUB_LSB = 4;
    localparam int PCS_CONT_LSB = 0;
    // Fixed filler bits of the first half
    localparam logic [5:0] PCS_FILL = 6'h00;
    // Contents value for stomp and restart-from-retry
    localparam logic [3:0] PCS_CONT_ZERO = 4'h0;
    // Throttle codes
    localparam logic [3:0] PCS_THR_MAX = 4'hA;
    localparam logic [3:0] PCS_THR_DRIFT = 4'hE;
    localparam logic [3:0] PCS_THR_STOP = 4'hF;
    localparam int PCS_CNT_W = 11;
    localparam logic [10:0] PCS_CNT_ONE = 11'h001;

    typedef enum logic [2:0] {
        PCS_IDLE = 3'b000,
        PCS_STOMP = 3'b001,
        PCS_EOP = 3'b010,
        PCS_RESTART = 3'b011,
        PCS_THROTTLE = 3'b100,
        PCS_MCAST = 3'b101
    } pcs_sub_t;
endpackage : pcs_pkg

/* pcs_link_if.sv */
// Purpose: Symbol lanes between the two link port ends
// Assumes: Both ends share clock; one 32-bit symbol per valid cycle
// Notes: Each end drives its own lane toward the other
`timescale 1ns/1ns
interface pcs_link_if;
    logic [31:0] tx_sym;
    logic tx_valid;
    logic [31:0] rx_sym;
    logic rx_valid;
    modport local_end (output tx_sym, output tx_valid,
        input rx_sym, input rx_valid);
    modport far_end (input tx_sym, input tx_valid,
        output rx_sym, output rx_valid);
endinterface : pcs_link_if

/* pcs_far_end.sv */
// Purpose: Far-end link port codec: sends throttle, eop, stomp and others
// Assumes: Receives symbols from the documented end on tx lane
// Notes: Same symbol format as the local end; contents come from send_cont except for stomp and restart
`timescale 1ns/1ns
module pcs_far_end
    import pcs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Link
    pcs_link_if.far_end link,
    // Send request
    input wire logic send_req,
    input wire logic [2:0] send_sub,
    input wire logic [3:0] send_cont,
    // Received symbol
    output logic got_valid,
    output logic [2:0] got_sub,
    output logic [3:0] got_cont
);
    logic [31:0] sym_q, sym_d;
    logic val_q, val_d;
    logic gv_q, gv_d;
    logic [2:0] gs_q, gs_d;
    logic [3:0] gc_q, gc_d;
    logic [15:0] h;
    logic [15:0] rh;
    logic ok;

    always_comb begin
        h = '0;
        h[PCS_STYPE_LSB +: 3] = PCS_STYPE_PKT;
        h[PCS_SUB_LSB +: 3] = send_sub;
        h[PCS_CONT_LSB +: 4] = (send_sub == 3'(PCS_STOMP)
            || send_sub == 3'(PCS_RESTART)) ? PCS_CONT_ZERO
            : send_cont;
        sym_d = {h, ~h};
        val_d = send_req && send_sub < 3'h6;
        rh = link.tx_sym[31:16];
        ok = link.tx_valid && (link.tx_sym[15:0] == ~rh)
            && rh[PCS_STYPE_LSB +: 3] == PCS_STYPE_PKT
            && rh[PCS_SUB_LSB +: 3] < 3'h6;
        gv_d = ok;
        gs_d = ok ? rh[PCS_SUB_LSB +: 3] : gs_q;
        gc_d = ok ? rh[PCS_CONT_LSB +: 4] : gc_q;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sym_q <= '0;
            val_q <= 1'b0;
            gv_q <= 1'b0;
            gs_q <= '0;
            gc_q <= '0;
        end else begin
            sym_q <= sym_d;
            val_q <= val_d;
            gv_q <= gv_d;
            gs_q <= gs_d;
            gc_q <= gc_d;
        end
    end

    assign link.rx_sym = sym_q;
    assign link.rx_valid = val_q;
    assign got_valid = gv_q;
    assign got_sub = gs_q;
    assign got_cont = gc_q;
endmodule : pcs_far_end

/* pcs_local_end.sv */
// Purpose: Documented link port codec with throttle pacing idle insertion
// Assumes: One symbol per cycle; far end keeps the same coding
// Notes: Pacing idles replace requested symbols while the count runs
`timescale 1ns/1ns
module pcs_local_end
    import pcs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Link
    pcs_link_if.local_end link,
    // Local state
    input wire logic [3:0] buf_status,
    input wire logic in_packet,
    // Send request
    input wire logic send_req,
    input wire logic [2:0] send_sub,
    input wire logic [3:0] send_cont,
    // Pacing
    output logic pace_idle,
    output logic pace_drift,
    // Received symbol
    output logic got_valid,
    output logic [2:0] got_sub,
    output logic [3:0] got_cont,
    output logic got_ends_pkt
);
    logic [31:0] sym_q, sym_d;
    logic val_q, val_d;
    logic [PCS_CNT_W-1:0] cnt_q, cnt_d;
    logic drift_q, drift_d;
    logic gv_q, gv_d;
    logic [2:0] gs_q, gs_d;
    logic [3:0] gc_q, gc_d;
    logic end_q, end_d;
    logic [15:0] h;
    logic [15:0] rh;
    logic [2:0] rsub;
    logic [3:0] rcont;
    logic ok;
    logic pacing;

    // Transmit path
    always_comb begin
        pacing = cnt_q != '0;
        h = '0;
        h[PCS_STYPE_LSB +: 3] = PCS_STYPE_PKT;
        if (pacing) begin
            h[PCS_SUB_LSB +: 3] = PCS_IDLE;
            h[PCS_CONT_LSB +: 4] = buf_status;
        end else begin
            h[PCS_SUB_LSB +: 3] = send_sub;
            case (send_sub)
                PCS_IDLE, PCS_EOP, PCS_MCAST: begin
                    h[PCS_CONT_LSB +: 4] = buf_status;
                end
                PCS_STOMP, PCS_RESTART: begin
                    h[PCS_CONT_LSB +: 4] = PCS_CONT_ZERO;
                end
                default: begin
                    h[PCS_CONT_LSB +: 4] = send_cont;
                end
            endcase
        end
        sym_d = {h, ~h};
        val_d = pacing || (send_req && send_sub < 3'h6);
    end

    // Receive path
    always_comb begin
        rh = link.rx_sym[31:16];
        rsub = rh[PCS_SUB_LSB +: 3];
        rcont = rh[PCS_CONT_LSB +: 4];
        ok = link.rx_valid && (link.rx_sym[15:0] == ~rh)
            && rh[PCS_STYPE_LSB +: 3] == PCS_STYPE_PKT
            && rsub < 3'h6
            && !(rsub == 3'(PCS_THROTTLE) && rcont > PCS_THR_MAX
                && rcont < PCS_THR_DRIFT);
        // One idle leaves on every pacing cycle, so count every one
        cnt_d = pacing ? cnt_q - PCS_CNT_ONE : cnt_q;
        drift_d = drift_q && cnt_d != '0;
        if (ok && rsub == 3'(PCS_THROTTLE) && in_packet) begin
            if (rcont == PCS_THR_STOP) begin
                cnt_d = '0;
                drift_d = 1'b0;
            end else if (rcont == PCS_THR_DRIFT) begin
                cnt_d = PCS_CNT_ONE;
                drift_d = 1'b1;
            end else begin
                cnt_d = PCS_CNT_ONE << rcont;
                drift_d = 1'b0;
            end
        end
        gv_d = ok;
        gs_d = ok ? rsub : gs_q;
        gc_d = !ok ? gc_q : (rsub == 3'(PCS_STOMP)
            || rsub == 3'(PCS_RESTART)) ? PCS_CONT_ZERO : rcont;
        // Only eop, stomp and restart terminate; others are embedded
        end_d = ok && (rsub == 3'(PCS_EOP) || rsub == 3'(PCS_STOMP)
            || rsub == 3'(PCS_RESTART));
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sym_q <= '0;
            val_q <= 1'b0;
            cnt_q <= '0;
            drift_q <= 1'b0;
            gv_q <= 1'b0;
            gs_q <= '0;
            gc_q <= '0;
            end_q <= 1'b0;
        end else begin
            sym_q <= sym_d;
            val_q <= val_d;
            cnt_q <= cnt_d;
            drift_q <= drift_d;
            gv_q <= gv_d;
            gs_q <= gs_d;
            gc_q <= gc_d;
            end_q <= end_d;
        end
    end

    assign link.tx_sym = sym_q;
    assign link.tx_valid = val_q;
    assign pace_idle = cnt_q != '0;
    assign pace_drift = drift_q;
    assign got_valid = gv_q;
    assign got_sub = gs_q;
    assign got_cont = gc_q;
    assign got_ends_pkt = end_q;
endmodule : pcs_local_end

/* pcs_monitor.sv */
// Purpose: Coding checks on both symbol lanes
// Assumes: One shared clock
// Notes: Instantiated beside the link interface
`timescale 1ns/1ns
module pcs_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Lanes
    input wire logic [31:0] tx_sym,
    input wire logic tx_valid,
    input wire logic [31:0] rx_sym,
    input wire logic rx_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_tx_half_inv: assert property (
        tx_valid |-> tx_sym[15:0] == ~tx_sym[31:16]) else $error("tx inv");
    a_rx_half_inv: assert property (
        rx_valid |-> rx_sym[15:0] == ~rx_sym[31:16]) else $error("rx inv");
    a_tx_type_fill: assert property (
        tx_valid |-> tx_sym[31:23] == 9'h100) else $error("tx type");
    a_rx_type_fill: assert property (
        rx_valid |-> rx_sym[31:23] == 9'h100) else $error("rx type");
    a_tx_sub_legal: assert property (
        tx_valid |-> tx_sym[22:20] < 3'h6) else $error("tx sub");
    a_rx_sub_legal: assert property (
        rx_valid |-> rx_sym[22:20] < 3'h6) else $error("rx sub");
    a_tx_zero_cont: assert property (
        tx_valid && tx_sym[20] && !tx_sym[22] |-> tx_sym[19:16] == 4'h0)
        else $error("tx cont");
    a_rx_zero_cont: assert property (
        rx_valid && rx_sym[20] && !rx_sym[22] |-> rx_sym[19:16] == 4'h0)
        else $error("rx cont");
    c_rx_thr: cover property (rx_valid && rx_sym[22:20] == 3'h4);
    c_tx_eop: cover property (tx_valid && tx_sym[22:20] == 3'h2);
    c_tx_run: cover property (tx_valid [*8]);
endmodule : pcs_monitor

/* packet_control_symbol_codec_test.sv */
// Purpose: Drives both codec ends against a bench model
// Assumes: Throttles obeyed only while in a packet
// Notes: Pacing counted on the falling edge
`timescale 1ns/1ns
module packet_control_symbol_codec_test;
    import pcs_pkg::*;
    logic clock, rstn, inp, lq, fq, pace, drift, lv, le, fv, hit, e;
    logic [2:0] ls, fs, lgs, fgs;
    logic [3:0] bs, lc, fc, lgc, fgc, c, ec;
    int error_cnt, compares, pn, idn, dn;
    pcs_link_if link ();
    pcs_local_end u_pcs_local_end (.clock(clock), .rstn(rstn),
        .link(link), .buf_status(bs), .in_packet(inp), .send_req(lq),
        .send_sub(ls), .send_cont(lc), .pace_idle(pace), .pace_drift(drift),
        .got_valid(lv), .got_sub(lgs), .got_cont(lgc), .got_ends_pkt(le));
    pcs_far_end u_pcs_far_end (.clock(clock), .rstn(rstn), .link(link),
        .send_req(fq), .send_sub(fs), .send_cont(fc), .got_valid(fv),
        .got_sub(fgs), .got_cont(fgc));
    pcs_monitor u_pcs_monitor (.clock(clock), .rstn(rstn),
        .tx_sym(link.tx_sym), .tx_valid(link.tx_valid),
        .rx_sym(link.rx_sym), .rx_valid(link.rx_valid));
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        pn += (pace === 1);
        dn += (pace === 1 && drift === 1);
        idn += (link.tx_valid === 1 && link.tx_sym[22:20] === 0);
    end
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic xfer(input logic f, input logic [2:0] s,
        input logic [3:0] v);
        @(posedge clock);
        fq <= f;
        lq <= !f;
        fs <= s;
        ls <= s;
        fc <= v;
        lc <= v;
        @(posedge clock);
        fq <= 0;
        lq <= 0;
        hit = 0;
        repeat (4) begin
            @(posedge clock);
            #1;
            if ((f ? lv : fv) === 1 && (f ? lgs : fgs) === s) begin
                hit = 1;
                e = le;
            end
        end
    endtask : xfer
    initial begin
        {rstn, inp, lq, fq, ls, fs, lc, fc, bs} = '0;
        repeat (4) @(posedge clock);
        rstn <= 1;
        void'($urandom(32'h1e7553b8));
        bs <= 4'($urandom);
        for (int f = 0; f < 2; f++) begin
            for (int s = 0; s < 8; s++) begin
                c = 4'($urandom);
                if (s == 4) c = c % 11;
                xfer(f[0], 3'(s), c);
                chk(hit, s < 6);
                if (s < 6) begin
                    chk(f ? lgs : fgs, 11'(s));
                    ec = (s == 1 || s == 3) ? 0 : (f || s == 4) ? c : bs;
                    chk(f ? lgc : fgc, ec);
                    if (f) chk(e, s inside {1, 2, 3});
                end
            end
        end
        @(posedge clock);
        inp <= 1;
        for (int k = 0; k < 16; k++) begin
            {pn, idn, dn} = '0;
            xfer(1, 3'h4, 4'(k));
            for (int i = 0; i < 1100 && pace === 1; i++) @(posedge clock);
            @(posedge clock);
            chk(hit, k < 11 || k > 13);
            chk(pn, k < 11 ? 1 << k : k == 14);
            chk(idn, pn);
            chk(dn, k == 14);
        end
        xfer(1, 3'h4, PCS_THR_MAX);
        xfer(0, 3'h2, 4'h0);
        chk(hit, 0);
        xfer(1, 3'h4, PCS_THR_STOP);
        chk(pace, 0);
        print_verdict();
    end
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end
endmodule : packet_control_symbol_codec_test
